// >>> pkg/irqr_pkg.sv
// How it works
// R1 - bit 2 set puts the control interrupt on a parallel pin, clear on serial frame.
// R2 - bit 3 clear makes the control interrupt active low, set active high.
// R3 - bit 4 clear drives the control interrupt push-pull, set open drain.
// R4 - bits 6:5 give the shared pin to wake, control interrupt or irq9; 11 reserved.
// R5 - bit 5 set tells the power block to ignore its control interrupt number.
// R6 - shared pin: wake low open drain, control interrupt programmed, irq9 high push-pull.
// R7 - bit 7 clear sends the management interrupt in serial slot 2, set on its pin.
// R8 - management pin polarity and buffer come from pin configuration, default low open drain.
// R9 - parallel mode disables rom buffer; serial and pci clock pins become irq15 and irq14.
// R10 - host writes may set forced change bits but never clear them.
// R11 - step and select line both high clear the matching forced change bit.
// R12 - media status is (sel0 and fc0) or (sel1 and fc1) or change input.
// R13 - forced change bit 0 is drive 0, bit 1 drive 1, bits 7:2 read zero.
// R14 - forced change register resets to 0x03.
// R15 - rate shadow mirrors reset, power down, write select and data rate; bit 5 zero.
// R16 - uart fifo shadow mirrors rx threshold in 7:6 and dma mode in bit 3.
// R17 - uart fifo shadow also reports tx reset, rx reset and fifo enable in bits 2:0.
// R18 - bit 0 clear selects serialized interrupts, set selects parallel interrupt pins.
// R19 - shadows capture each write of their source; writes to shadow addresses are ignored.
package irqr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_ROUTING = 8'hc0;
  localparam logic [7:0] IDX_FORCED_CHANGE = 8'hc1;
  localparam logic [7:0] IDX_RATE_SHADOW = 8'hc2;
  localparam logic [7:0] IDX_UART1_SHADOW = 8'hc3;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  localparam logic [7:0] RST_IRQ_ROUTING = 8'h00;
  localparam logic [7:0] RST_FORCED_CHANGE = 8'h03;
  localparam logic [7:0] RST_SHADOW = 8'h00;

  // routing control fields
  localparam int B_PAR_MODE = 0;
  localparam int B_SCI_SEL = 2;
  localparam int B_SCI_POL = 3;
  localparam int B_SCI_OD = 4;
  localparam int B_SHARED_LO = 5;
  localparam int B_SMI_SEL = 7;
  localparam logic [7:0] ROUTING_WMASK = 8'hfd;

  localparam logic [7:0] FC_MASK = 8'h03;
  localparam logic [7:0] RATE_MASK = 8'hdf;
  localparam logic [7:0] UART_MASK = 8'hcf;

  typedef enum logic [1:0] {
    SHARED_WAKE = 2'b00,
    SHARED_SCI = 2'b01,
    SHARED_IRQ9 = 2'b10,
    SHARED_RSVD = 2'b11
  } irqr_shared_t;

  // one two-way pin: level driven and its enable
  typedef struct packed {
    logic o;
    logic oe;
  } irqr_pin_t;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } irqr_wr_t;

endpackage : irqr_pkg

// >>> verilog/irqr_bank.sv
// Chosen here: the APB slave port.
`timescale 1ns/100ps
module irqr_bank
  import irqr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire irqr_wr_t RATE_REG_WR,
  input wire irqr_wr_t UART1_FCR_WR,
  input wire logic HEAD_STEP_PULSE_N,
  input wire logic DRIVE_SELECT0_N,
  input wire logic DRIVE_SELECT1_N,
  input wire logic MEDIA_CHANGED_IN_N,
  output logic MEDIA_CHANGED_STATUS,
  input wire logic SCI_EVENT,
  input wire logic SMI_EVENT,
  input wire logic WAKE_EVENT,
  input wire logic IRQ9_EVENT,
  input wire logic IRQ14_EVENT,
  input wire logic IRQ15_EVENT,
  input wire logic SMI_PIN_ACTIVE_HIGH,
  input wire logic SMI_PIN_PUSH_PULL,
  output logic SERIAL_FRAME_SCI_REQ,
  output logic SERIAL_FRAME_IRQ2_REQ,
  output logic SERIAL_IRQ_MODE,
  output logic SCI_IRQ_NUM_IGNORE,
  output logic ROM_BUFFER_EN,
  output irqr_pin_t SCI_PIN,
  output irqr_pin_t SHARED_PIN,
  output irqr_pin_t SYS_MGMT_IRQ_PIN_N,
  output irqr_pin_t SERIALIZED_IRQ_PIN_IRQ15,
  output irqr_pin_t PCI_CLK_PIN_IRQ14
);

  // drive a pin for an interrupt level with given polarity and buffer type
  function automatic irqr_pin_t pin_drive(input logic active, input logic act_high, input logic open_drain);
    irqr_pin_t p;
    logic lvl;
    lvl = active ~^ act_high;
    if (open_drain) begin
      p.o = 1'b0;
      p.oe = ~lvl;
    end else begin
      p.o = lvl;
      p.oe = 1'b1;
    end
    return p;
  endfunction : pin_drive

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] addr);
    return addr[IDX_LSB +: 8];
  endfunction : reg_index

  // aligned, nothing above the index, and one of the four register slots
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] slot;
    slot = reg_index(addr);
    return (addr[IDX_LSB-1:0] == '0) && (addr[ADDR_W-1:IDX_LSB+8] == '0) &&
           (slot == IDX_IRQ_ROUTING || slot == IDX_FORCED_CHANGE ||
            slot == IDX_RATE_SHADOW || slot == IDX_UART1_SHADOW);
  endfunction : is_mapped

  // a completed host write that lands on one register
  function automatic logic reg_wr_hit(input logic en, input logic ok, input logic [7:0] slot,
                                      input logic [7:0] want);
    return en && ok && (slot == want);
  endfunction : reg_wr_hit

  // a pin is driven only while its route is chosen, released otherwise
  function automatic irqr_pin_t pin_when(input logic chosen, input irqr_pin_t p);
    irqr_pin_t r;
    r = chosen ? p : '0;
    return r;
  endfunction : pin_when

  // fixed active-high push-pull drive of the plain irq pins
  function automatic irqr_pin_t pin_push_high(input logic active);
    return pin_drive(active, 1'b1, 1'b0);
  endfunction : pin_push_high

  // disk-change status as seen by the floppy input register
  function automatic logic media_status(input logic s0_n, input logic s1_n, input logic [1:0] fc,
                                        input logic c_n);
    return (s0_n & fc[0]) | (s1_n & fc[1]) | c_n;
  endfunction : media_status

  // the unmapped-address test needs address bits above the index
  if (ADDR_W <= IDX_LSB + 8) begin : g_addr_w_check
    $error("address bus too narrow for the register index");
  end

  logic [7:0] routing_q;
  logic [7:0] fc_q;
  logic [7:0] fc_d;
  logic [7:0] rate_q;
  logic [7:0] uart_q;

  // ---------------- apb slave ----------------
  logic setup;
  logic access;
  logic wr_en;
  logic [7:0] idx;
  logic [7:0] idx_acc;
  logic mapped;
  logic [7:0] rd_val;

  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE & PREADY;
  assign wr_en = access & PWRITE;
  assign idx = reg_index(PADDR);
  assign idx_acc = idx;
  assign mapped = is_mapped(PADDR);

  always_comb begin
    rd_val = 8'h00;
    case (idx)
      IDX_IRQ_ROUTING: rd_val = routing_q;
      IDX_FORCED_CHANGE: rd_val = fc_q & FC_MASK; // [R13]
      IDX_RATE_SHADOW: rd_val = rate_q; // [R15]
      IDX_UART1_SHADOW: rd_val = uart_q; // [R16] [R17]
      default: rd_val = 8'h00;
    endcase
  end

  // answer one cycle after setup, no wait states
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= setup;
    end
  end

  // read data is taken at setup and stands through the single access cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      PRDATA <= '0;
    end else if (setup) begin
      PRDATA <= (mapped && !PWRITE) ? {24'h000000, rd_val} : '0;
    end else if (access) begin
      PRDATA <= '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PSLVERR <= ~mapped;
    end else if (access) begin
      PSLVERR <= 1'b0;
    end
  end

  // ---------------- routing control ----------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      routing_q <= RST_IRQ_ROUTING;
    end else if (reg_wr_hit(wr_en, mapped, idx_acc, IDX_IRQ_ROUTING)) begin
      routing_q <= PWDATA[7:0] & ROUTING_WMASK;
    end
  end

  // ---------------- shadows ----------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      rate_q <= RST_SHADOW;
    end else if (RATE_REG_WR.wr) begin
      rate_q <= RATE_REG_WR.data & RATE_MASK; // [R15] [R19]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      uart_q <= RST_SHADOW;
    end else if (UART1_FCR_WR.wr) begin
      uart_q <= UART1_FCR_WR.data & UART_MASK; // [R16] [R17] [R19]
    end
  end

  // ---------------- floppy pin synchronisers ----------------
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_q;

  // three stages; a new level counts once stages two and three agree
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s1 <= 4'h0;
    end else begin
      pin_s1 <= {MEDIA_CHANGED_IN_N, DRIVE_SELECT1_N, DRIVE_SELECT0_N, HEAD_STEP_PULSE_N};
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s2 <= 4'h0;
    end else begin
      pin_s2 <= pin_s1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_s3 <= 4'h0;
    end else begin
      pin_s3 <= pin_s2;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_q <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_q[i] <= pin_s3[i];
        end
      end
    end
  end

  logic step_n;
  logic sel0_n;
  logic sel1_n;
  logic chg_n;
  assign step_n = pin_q[0];
  assign sel0_n = pin_q[1];
  assign sel1_n = pin_q[2];
  assign chg_n = pin_q[3];

  // ---------------- forced disk change ----------------
  always_comb begin
    fc_d = fc_q & FC_MASK;
    if (step_n && sel0_n) begin
      fc_d[0] = 1'b0; // [R11]
    end
    if (step_n && sel1_n) begin
      fc_d[1] = 1'b0; // [R11]
    end
    // a host set lands after the clear so it wins
    if (reg_wr_hit(wr_en, mapped, idx_acc, IDX_FORCED_CHANGE)) begin
      fc_d = fc_d | (PWDATA[7:0] & FC_MASK); // [R10] [R13]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      fc_q <= RST_FORCED_CHANGE; // [R14]
    end else begin
      fc_q <= fc_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      MEDIA_CHANGED_STATUS <= 1'b0;
    end else begin
      MEDIA_CHANGED_STATUS <= media_status(sel0_n, sel1_n, fc_q[1:0], chg_n); // [R12]
    end
  end

  // ---------------- interrupt routing ----------------
  logic par_mode;
  logic sci_on_pin;
  logic sci_high;
  logic sci_od;
  logic smi_on_pin;
  irqr_shared_t shared_sel;

  assign par_mode = routing_q[B_PAR_MODE];
  assign sci_on_pin = routing_q[B_SCI_SEL];
  assign sci_high = routing_q[B_SCI_POL];
  assign sci_od = routing_q[B_SCI_OD];
  assign smi_on_pin = routing_q[B_SMI_SEL];
  assign shared_sel = irqr_shared_t'(routing_q[B_SHARED_LO +: 2]);

  irqr_pin_t shared_d;
  always_comb begin
    case (shared_sel)
      SHARED_WAKE: shared_d = pin_drive(WAKE_EVENT, 1'b0, 1'b1); // [R6]
      SHARED_SCI: shared_d = pin_drive(SCI_EVENT, sci_high, sci_od); // [R6]
      SHARED_IRQ9: shared_d = pin_push_high(IRQ9_EVENT); // [R6]
      default: shared_d = '{o: 1'b0, oe: 1'b0}; // [R4]
    endcase
  end

  // frame requests go out only while the interrupt is not routed to a pin
  always_ff @(posedge CLK) begin
    if (RST) begin
      SERIAL_FRAME_SCI_REQ <= 1'b0;
    end else begin
      SERIAL_FRAME_SCI_REQ <= SCI_EVENT & ~sci_on_pin; // [R1]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SERIAL_FRAME_IRQ2_REQ <= 1'b0;
    end else begin
      SERIAL_FRAME_IRQ2_REQ <= SMI_EVENT & ~smi_on_pin; // [R7]
    end
  end

  // reset value matches a cleared routing register: serialized mode
  always_ff @(posedge CLK) begin
    if (RST) begin
      SERIAL_IRQ_MODE <= 1'b1;
    end else begin
      SERIAL_IRQ_MODE <= ~par_mode; // [R18]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SCI_IRQ_NUM_IGNORE <= 1'b0;
    end else begin
      SCI_IRQ_NUM_IGNORE <= routing_q[B_SHARED_LO]; // [R5]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ROM_BUFFER_EN <= 1'b1;
    end else begin
      ROM_BUFFER_EN <= ~par_mode; // [R9]
    end
  end

  // push-pull drives both levels, open drain only pulls low; unrouted pins float
  always_ff @(posedge CLK) begin
    if (RST) begin
      SCI_PIN <= '0;
    end else begin
      SCI_PIN <= pin_when(sci_on_pin, pin_drive(SCI_EVENT, sci_high, sci_od)); // [R1] [R2] [R3]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SHARED_PIN <= '0;
    end else begin
      SHARED_PIN <= shared_d; // [R4]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      SYS_MGMT_IRQ_PIN_N <= '0;
    end else begin
      SYS_MGMT_IRQ_PIN_N <= pin_when(smi_on_pin, pin_drive(SMI_EVENT, SMI_PIN_ACTIVE_HIGH, ~SMI_PIN_PUSH_PULL)); // [R7] [R8]
    end
  end

  // in parallel mode the serial line and pci clock pins carry irq15 and irq14
  always_ff @(posedge CLK) begin
    if (RST) begin
      SERIALIZED_IRQ_PIN_IRQ15 <= '0;
    end else begin
      SERIALIZED_IRQ_PIN_IRQ15 <= pin_when(par_mode, pin_push_high(IRQ15_EVENT)); // [R9]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PCI_CLK_PIN_IRQ14 <= '0;
    end else begin
      PCI_CLK_PIN_IRQ14 <= pin_when(par_mode, pin_push_high(IRQ14_EVENT)); // [R9]
    end
  end

endmodule : irqr_bank

// >>> dv/irqr_bank_asserts.sv
`timescale 1ns/100ps
module irqr_bank_asserts
  import irqr_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic MEDIA_CHANGED_IN_N,
  input wire logic MEDIA_CHANGED_STATUS,
  input wire logic SERIAL_FRAME_SCI_REQ,
  input wire logic SERIAL_FRAME_IRQ2_REQ,
  input wire irqr_pin_t SCI_PIN,
  input wire irqr_pin_t SYS_MGMT_IRQ_PIN_N
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic rd;
  assign rd = PREADY && !PWRITE;
  property p_sh; PREADY && (PADDR == 12'h308 || PADDR == 12'h30c) |-> !PSLVERR; endproperty
  a_sh: assert property (p_sh) else $error("shadow error");
  property p_fc; rd && PADDR == 12'h304 |-> PRDATA[31:2] == 30'h0; endproperty
  a_fc: assert property (p_fc) else $error("fc bits");
  property p_rt; rd && PADDR == 12'h308 |-> PRDATA[31:8] == 24'h0 && !PRDATA[5]; endproperty
  a_rt: assert property (p_rt) else $error("rate bits");
  property p_ua; rd && PADDR == 12'h30c |-> PRDATA[31:8] == 24'h0 && PRDATA[5:4] == 2'h0; endproperty
  a_ua: assert property (p_ua) else $error("fifo bits");
  property p_sci; !(SCI_PIN.oe && SERIAL_FRAME_SCI_REQ); endproperty
  a_sci: assert property (p_sci) else $error("sci twice");
  property p_smi; SERIAL_FRAME_IRQ2_REQ |-> SYS_MGMT_IRQ_PIN_N == 2'h0; endproperty
  a_smi: assert property (p_smi) else $error("smi twice");
  property p_med; MEDIA_CHANGED_IN_N [*6] |=> MEDIA_CHANGED_STATUS; endproperty
  a_med: assert property (p_med) else $error("media lost");
  property p_one; PREADY |=> !PREADY; endproperty
  a_one: assert property (p_one) else $error("ready long");
  c_wr: cover property (PREADY && PWRITE);
  c_irq2: cover property (SERIAL_FRAME_IRQ2_REQ);
  c_med: cover property (MEDIA_CHANGED_STATUS);
endmodule : irqr_bank_asserts
bind irqr_bank irqr_bank_asserts u_chk (.*);

// >>> dv/irqr_bank_tb_top.sv
`timescale 1ns/100ps
module irqr_bank_tb_top
  import irqr_pkg::*;
;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, e;
  logic [ADDR_W-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, r;
  logic PREADY, PSLVERR, MEDIA_CHANGED_STATUS, SERIAL_FRAME_SCI_REQ, SERIAL_FRAME_IRQ2_REQ;
  logic SERIAL_IRQ_MODE, SCI_IRQ_NUM_IGNORE, ROM_BUFFER_EN;
  irqr_wr_t RATE_REG_WR = '0, UART1_FCR_WR = '0;
  logic HEAD_STEP_PULSE_N = 0, DRIVE_SELECT0_N = 0, DRIVE_SELECT1_N = 0, MEDIA_CHANGED_IN_N = 0;
  logic SCI_EVENT = 0, SMI_EVENT = 0, WAKE_EVENT = 0, IRQ9_EVENT = 0, IRQ14_EVENT = 0, IRQ15_EVENT = 0;
  logic SMI_PIN_ACTIVE_HIGH = 0, SMI_PIN_PUSH_PULL = 0;
  irqr_pin_t SCI_PIN, SHARED_PIN, SYS_MGMT_IRQ_PIN_N, SERIALIZED_IRQ_PIN_IRQ15, PCI_CLK_PIN_IRQ14, x;
  logic [7:0] v;
  logic [1:0] f;
  int failures = 0, compares = 0;
  irqr_bank uut (.CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RATE_REG_WR,
    .UART1_FCR_WR, .HEAD_STEP_PULSE_N, .DRIVE_SELECT0_N, .DRIVE_SELECT1_N, .MEDIA_CHANGED_IN_N, .MEDIA_CHANGED_STATUS,
    .SCI_EVENT, .SMI_EVENT, .WAKE_EVENT, .IRQ9_EVENT, .IRQ14_EVENT, .IRQ15_EVENT, .SMI_PIN_ACTIVE_HIGH,
    .SMI_PIN_PUSH_PULL, .SERIAL_FRAME_SCI_REQ, .SERIAL_FRAME_IRQ2_REQ, .SERIAL_IRQ_MODE, .SCI_IRQ_NUM_IGNORE,
    .ROM_BUFFER_EN, .SCI_PIN, .SHARED_PIN, .SYS_MGMT_IRQ_PIN_N, .SERIALIZED_IRQ_PIN_IRQ15, .PCI_CLK_PIN_IRQ14);
  initial forever #50 CLK = ~CLK;
  task automatic give_verdict();
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] ex);
    compares++;
    if (s !== ex) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", n, ex, s);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge CLK);
  endtask : apb
  // pin level and enable for a given polarity and buffer kind
  function automatic irqr_pin_t pe(input logic ev, input logic hi, input logic od);
    return od ? {1'b0, hi ^ ev} : {hi ~^ ev, 1'b1};
  endfunction : pe
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'hfe12335b));
    repeat (6) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    apb(0, 12'h300, 0);
    chk("rt0", r, 0);
    apb(0, 12'h304, 0);
    chk("fc0", r, 3);
    apb(1, 12'h310, 0);
    chk("bad", e, 1);
    f = 3;
    for (int i = 0; i < 12; i++) begin
      v = i ? 8'($urandom) : 8'hff;
      {HEAD_STEP_PULSE_N, DRIVE_SELECT1_N, DRIVE_SELECT0_N, MEDIA_CHANGED_IN_N} <= v[3:0];
      RATE_REG_WR <= {1'b1, v};
      UART1_FCR_WR <= {1'b1, ~v};
      @(posedge CLK);
      RATE_REG_WR.wr <= 0;
      UART1_FCR_WR.wr <= 0;
      repeat (8) @(posedge CLK);
      if (v[3]) f &= ~v[2:1];
      chk("dc", MEDIA_CHANGED_STATUS, DRIVE_SELECT0_N & f[0] | DRIVE_SELECT1_N & f[1] | MEDIA_CHANGED_IN_N);
      apb(0, 12'h304, 0);
      chk("fc", r, f);
      HEAD_STEP_PULSE_N <= 0;
      apb(1, 12'h308, ~v);
      apb(0, 12'h308, 0);
      chk("rs", r, v & 8'hdf);
      apb(0, 12'h30c, 0);
      chk("us", r, ~v & 8'hcf);
      apb(1, 12'h304, v >> 4);
      f |= v[5:4];
    end
    for (int i = 0; i < 40; i++) begin
      v = i < 4 ? {1'b1, 2'(i), 5'h1f} : 8'($urandom);
      {SCI_EVENT, SMI_EVENT, WAKE_EVENT, IRQ9_EVENT, SMI_PIN_ACTIVE_HIGH, SMI_PIN_PUSH_PULL, IRQ14_EVENT,
       IRQ15_EVENT} <= 8'($urandom);
      apb(1, 12'h300, v);
      apb(0, 12'h300, 0);
      chk("rt", r, v & 8'hfd);
      case (v[6:5])
        2'h0: x = pe(WAKE_EVENT, 0, 1);
        2'h1: x = pe(SCI_EVENT, v[3], v[4]);
        2'h2: x = pe(IRQ9_EVENT, 1, 0);
        default: x = 0;
      endcase
      chk("shr", SHARED_PIN, x);
      x = v[2] ? pe(SCI_EVENT, v[3], v[4]) : 2'h0;
      chk("sci", {SCI_PIN, SERIAL_FRAME_SCI_REQ}, {x, !v[2] & SCI_EVENT});
      x = v[7] ? pe(SMI_EVENT, SMI_PIN_ACTIVE_HIGH, !SMI_PIN_PUSH_PULL) : 2'h0;
      chk("smi", {SYS_MGMT_IRQ_PIN_N, SERIAL_FRAME_IRQ2_REQ}, {x, !v[7] & SMI_EVENT});
      chk("mux", {SCI_IRQ_NUM_IGNORE, SERIAL_IRQ_MODE, ROM_BUFFER_EN}, {v[5], !v[0], !v[0]});
      x = v[0] ? pe(IRQ15_EVENT, 1, 0) : 2'h0;
      chk("irq15", SERIALIZED_IRQ_PIN_IRQ15, x);
      x = v[0] ? pe(IRQ14_EVENT, 1, 0) : 2'h0;
      chk("irq14", PCI_CLK_PIN_IRQ14, x);
    end
    give_verdict();
  end
endmodule : irqr_bank_tb_top
